// ### omr_consts.svh
// Constants of the optical motion readout block: addresses, resets, limits.
// Assumes inclusion by the block's package and design file only.
`ifndef OMR_CONSTS_SVH
`define OMR_CONSTS_SVH

// Register addresses on the serial port (7-bit)
`define OMR_A_PID 7'h00
`define OMR_A_REV 7'h01
`define OMR_A_STATUS 7'h02
`define OMR_A_XCNT 7'h03
`define OMR_A_YCNT 7'h04
`define OMR_A_QUALITY 7'h05
`define OMR_A_SHUT_UP 7'h06
`define OMR_A_SHUT_LOW 7'h07
`define OMR_A_BRIGHT 7'h08
`define OMR_A_SUM 7'h09
`define OMR_A_DARK 7'h0a
`define OMR_A_GRAB 7'h0b
`define OMR_A_NIBBLE 7'h0c
`define OMR_A_CTRL 7'h0d

// Reset values
`define OMR_RST_SHUTTER 16'h0064
`define OMR_RST_BRIGHT 8'hd0
`define OMR_RST_SUM 8'h80
`define OMR_RST_CTRL 8'h01

// Field positions
`define OMR_CTRL_WIDE_BIT 7
`define OMR_GRAB_VALID_BIT 7

// Value limits
`define OMR_QUALITY_MAX 8'hb4
`define OMR_PIX_CEIL 8'hfe
`define OMR_SUM_MAX 17'h1_e038
`define OMR_LIM12 13'sh07ff
`define OMR_LIM8 13'sh007f

// Pixel grabber geometry
`define OMR_GRAB_LAST 9'h1e3

// Exposure loop thresholds and step
`define OMR_EXP_PEAK_HI 8'hf0
`define OMR_EXP_PEAK_LO 8'h80
`define OMR_EXP_AVG_HI 8'hc0
`define OMR_EXP_AVG_LO 8'h40
`define OMR_EXP_STEP 16'h0004
`define OMR_EXP_MIN 16'h0008

`endif

// ### omr_host_model.sv
// Serial master model of the host microcontroller, mode 3, MSB first.
// Assumes the bench calls xfer once per command and data byte pair.
`timescale 1ns/10ps
module omr_host_model (
  output logic ncs,
  output logic sclk,
  output logic mosi,
  input wire logic miso
);
  // Half period of the link clock; sclk rests high between frames
  parameter realtime HALF = 80.0;

  initial begin
    ncs = 1'b1;
    sclk = 1'b1;
    mosi = 1'b0;
  end

  // Command byte then data byte; gap stretches the pause after the command
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, input int gap,
    output logic [7:0] rd);
    logic [15:0] sh;
    sh = {cmd, wd};
    #0.7;
    ncs = 1'b0;
    #(HALF);
    for (int i = 15; i >= 0; i--) begin
      sclk = 1'b0;
      // On reads the data slot toggles, so no stale level is mistaken for data
      mosi = (i < 8 && !cmd[7]) ? ~mosi : sh[i];
      #(HALF);
      sclk = 1'b1;
      if (i < 8) rd[i] = miso;
      #(HALF);
      if (i == 8) #(gap * HALF);
    end
    mosi = ~mosi;
    ncs = 1'b1;
    #(HALF);
  endtask
endmodule

// ### omr_pkg.sv
// Types of the optical motion readout block.
// Assumes the constants header sits in the same folder.
`include "omr_consts.svh"

package omr_pkg;

  // Per-frame results from the image processor
  typedef struct packed {
    logic [11:0] dx;
    logic [11:0] dy;
    logic [8:0] feature_cnt;
    logic [16:0] pix_sum;
    logic [7:0] pix_peak;
    logic [7:0] pix_low;
  } omr_frame_t;

  // One pixel of the frame as it streams out of the array
  typedef struct packed {
    logic [8:0] index;
    logic [7:0] value;
  } omr_pixel_t;

  // Serial port states
  typedef enum logic [3:0] {
    OMR_IDLE = 4'b0001,
    OMR_ADDR = 4'b0010,
    OMR_RDATA = 4'b0100,
    OMR_WDATA = 4'b1000
  } omr_state_t;

endpackage

// ### omr_readout.sv
// Read-side register logic of an optical motion sensor, with its serial port.
// Assumes frame results and the pixel stream arrive on the core clock,
// and that the serial pins come straight from the outside world.
`timescale 1ns/10ps
`include "omr_consts.svh"

module omr_readout
  import omr_pkg::*;
#(
  parameter logic [7:0] PRODUCT_ID = 8'h5c, // Arbitrary value
  parameter logic [7:0] REVISION = 8'h01 // Arbitrary value
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic ncs,
  input wire logic sclk,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic frame_valid,
  input wire omr_frame_t frame,
  input wire logic pixel_valid,
  input wire omr_pixel_t pixel,
  output logic [15:0] shutter_time
);

  // Saturating add of a frame's motion onto an accumulated count
  function automatic logic [11:0] sat_add(input logic [11:0] a,
                                          input logic [11:0] b,
                                          input logic wide);
    logic signed [12:0] s;
    logic signed [12:0] hi;
    s = $signed({a[11], a}) + $signed({b[11], b});
    hi = wide ? `OMR_LIM12 : `OMR_LIM8;
    if (s > hi) begin
      s = hi;
    end else if (s < -hi - 13'sd1) begin
      s = -hi - 13'sd1;
    end
    return s[11:0];
  endfunction

  // Clamp of an 8-bit statistic to a ceiling
  function automatic logic [7:0] clamp8(input logic [7:0] v,
                                        input logic [7:0] lim);
    return (v > lim) ? lim : v;
  endfunction

  // ---------------------------------------------------------------
  // Pin synchronisers: ncs, sclk, mosi pass two flops before use
  logic [2:0] sync1_ff;
  logic [2:0] sync2_ff;
  logic sclk_d_ff;
  logic [2:0] nxt_sync1;
  logic [2:0] nxt_sync2;
  logic nxt_sclk_d;

  // First stage feeds only the second stage
  always_comb begin
    nxt_sync1 = {ncs, sclk, mosi};
    nxt_sync2 = sync1_ff;
    nxt_sclk_d = sync2_ff[1];
  end

  // Idle pins look like a deselected port after reset
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sync1_ff <= 3'h6;
      sync2_ff <= 3'h6;
      sclk_d_ff <= 1'b1;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
      sclk_d_ff <= nxt_sclk_d;
    end
  end

  // ---------------------------------------------------------------
  // Register state
  logic [11:0] x_ff;
  logic [11:0] y_ff;
  logic [3:0] x_hi_ff;
  logic [3:0] y_hi_ff;
  logic motion_seen_flag_ff;
  logic [7:0] surface_quality_ff;
  logic [15:0] shutter_ff;
  logic [7:0] shut_low_shadow_ff;
  logic shadow_armed_ff;
  logic [7:0] brightest_pixel_ff;
  logic [7:0] pixel_sum_upper_ff;
  logic [7:0] darkest_pixel_ff;
  logic [7:0] pixel_capture_ff;
  logic [8:0] grab_index_ff;
  logic [7:0] ctrl_ff;

  // ---------------------------------------------------------------
  // Serial port engine
  omr_state_t state_ff;
  logic [2:0] bit_ff;
  logic [7:0] shift_ff;
  logic [6:0] addr_ff;
  logic [7:0] out_ff;
  logic miso_ff;
  logic oe_ff;
  omr_state_t nxt_state;
  logic [2:0] nxt_bit;
  logic [7:0] nxt_shift;
  logic [6:0] nxt_addr;
  logic [7:0] nxt_out;
  logic nxt_miso;
  logic nxt_oe;
  logic rd_pulse;
  logic wr_pulse;
  logic [7:0] cmd;
  logic [7:0] rdata;
  logic rise;
  logic fall;

  // Read data picked from the byte just shifted in
  always_comb begin
    cmd = {shift_ff[6:0], sync2_ff[0]};
    case (cmd[6:0])
      `OMR_A_PID: rdata = PRODUCT_ID;
      `OMR_A_REV: rdata = REVISION;
      `OMR_A_STATUS: rdata = {motion_seen_flag_ff, 7'h00};
      `OMR_A_XCNT: rdata = x_ff[7:0];
      `OMR_A_YCNT: rdata = y_ff[7:0];
      `OMR_A_QUALITY: rdata = surface_quality_ff;
      `OMR_A_SHUT_UP: rdata = shutter_ff[15:8];
      // Lower byte pairs with the upper byte read just before it
      `OMR_A_SHUT_LOW: rdata = shadow_armed_ff ? shut_low_shadow_ff : shutter_ff[7:0];
      `OMR_A_BRIGHT: rdata = brightest_pixel_ff;
      `OMR_A_SUM: rdata = pixel_sum_upper_ff;
      `OMR_A_DARK: rdata = darkest_pixel_ff;
      `OMR_A_GRAB: rdata = pixel_capture_ff;
      `OMR_A_NIBBLE: rdata = {x_hi_ff, y_hi_ff};
      `OMR_A_CTRL: rdata = ctrl_ff;
      default: rdata = 8'h00;
    endcase
  end

  // Mode 3 framing: sample on sclk rise, change miso on sclk fall.
  // Bit 7 of the first byte selects write; a port may carry several
  // commands under one ncs low.
  always_comb begin
    nxt_state = state_ff;
    nxt_bit = bit_ff;
    nxt_shift = shift_ff;
    nxt_addr = addr_ff;
    nxt_out = out_ff;
    nxt_miso = miso_ff;
    nxt_oe = oe_ff;
    rd_pulse = 1'b0;
    wr_pulse = 1'b0;
    rise = sync2_ff[1] & ~sclk_d_ff;
    fall = ~sync2_ff[1] & sclk_d_ff;
    if (sync2_ff[2]) begin
      nxt_state = OMR_IDLE;
      nxt_bit = 3'h0;
      nxt_oe = 1'b0;
    end else begin
      case (state_ff)
        OMR_IDLE: begin
          nxt_state = OMR_ADDR;
          nxt_bit = 3'h0;
          nxt_oe = 1'b1;
        end
        OMR_ADDR: begin
          if (rise) begin
            nxt_shift = cmd;
            nxt_bit = bit_ff + 3'h1;
            if (bit_ff == 3'h7) begin
              nxt_addr = cmd[6:0];
              if (cmd[7]) begin
                nxt_state = OMR_WDATA;
              end else begin
                nxt_state = OMR_RDATA;
                nxt_out = rdata;
                rd_pulse = 1'b1;
              end
            end
          end
        end
        OMR_RDATA: begin
          if (fall) begin
            nxt_miso = out_ff[7];
            nxt_out = {out_ff[6:0], 1'b0};
          end
          if (rise) begin
            nxt_bit = bit_ff + 3'h1;
            if (bit_ff == 3'h7) begin
              nxt_state = OMR_ADDR;
            end
          end
        end
        OMR_WDATA: begin
          if (rise) begin
            nxt_shift = cmd;
            nxt_bit = bit_ff + 3'h1;
            if (bit_ff == 3'h7) begin
              wr_pulse = 1'b1;
              nxt_state = OMR_ADDR;
            end
          end
        end
        default: begin
          nxt_state = OMR_IDLE;
        end
      endcase
    end
  end

  // Port registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_ff <= OMR_IDLE;
      bit_ff <= 3'h0;
      shift_ff <= 8'h00;
      addr_ff <= 7'h00;
      out_ff <= 8'h00;
      miso_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      bit_ff <= nxt_bit;
      shift_ff <= nxt_shift;
      addr_ff <= nxt_addr;
      out_ff <= nxt_out;
      miso_ff <= nxt_miso;
      oe_ff <= nxt_oe;
    end
  end

  assign miso = miso_ff;
  assign miso_oe = oe_ff;
  assign shutter_time = shutter_ff;

  // ---------------------------------------------------------------
  // Register effects of frames, reads and writes
  logic [11:0] nxt_x;
  logic [11:0] nxt_y;
  logic [3:0] nxt_x_hi;
  logic [3:0] nxt_y_hi;
  logic nxt_flag;
  logic [7:0] nxt_quality;
  logic [15:0] nxt_shutter;
  logic [7:0] nxt_shadow;
  logic nxt_armed;
  logic [7:0] nxt_bright;
  logic [7:0] nxt_sum;
  logic [7:0] nxt_dark;
  logic [7:0] nxt_grab;
  logic [8:0] nxt_grab_index;
  logic [7:0] nxt_ctrl;
  logic wide;
  logic wr_status;
  logic rd_grab;

  // Clears from the port come first so a same-cycle frame still lands
  always_comb begin
    nxt_x = x_ff;
    nxt_y = y_ff;
    nxt_x_hi = x_hi_ff;
    nxt_y_hi = y_hi_ff;
    nxt_flag = motion_seen_flag_ff;
    nxt_quality = surface_quality_ff;
    nxt_shutter = shutter_ff;
    nxt_shadow = shut_low_shadow_ff;
    nxt_armed = shadow_armed_ff;
    nxt_bright = brightest_pixel_ff;
    nxt_sum = pixel_sum_upper_ff;
    nxt_dark = darkest_pixel_ff;
    nxt_grab = pixel_capture_ff;
    nxt_grab_index = grab_index_ff;
    nxt_ctrl = ctrl_ff;
    wide = ctrl_ff[`OMR_CTRL_WIDE_BIT];
    wr_status = wr_pulse && (addr_ff == `OMR_A_STATUS);
    rd_grab = rd_pulse && (cmd[6:0] == `OMR_A_GRAB);
    // Any other access breaks the upper-then-lower shutter pairing
    if (rd_pulse || wr_pulse) begin
      nxt_armed = 1'b0;
    end
    if (rd_pulse && (cmd[6:0] == `OMR_A_SHUT_UP)) begin
      nxt_shadow = shutter_ff[7:0];
      nxt_armed = 1'b1;
    end
    // Reading a count hands its upper nibble to the nibble register
    if (rd_pulse && (cmd[6:0] == `OMR_A_XCNT)) begin
      nxt_x = 12'h000;
      nxt_x_hi = x_ff[11:8];
    end
    if (rd_pulse && (cmd[6:0] == `OMR_A_YCNT)) begin
      nxt_y = 12'h000;
      nxt_y_hi = y_ff[11:8];
    end
    if (wr_status) begin
      nxt_x = 12'h000;
      nxt_y = 12'h000;
      nxt_flag = 1'b0;
    end
    if (wr_pulse && (addr_ff == `OMR_A_CTRL)) begin
      // The last data bit is not in shift_ff yet, so take the full byte
      nxt_ctrl = cmd;
    end
    // Grabber: write rewinds, valid read advances, else capture
    if (wr_pulse && (addr_ff == `OMR_A_GRAB)) begin
      nxt_grab = 8'h00;
      nxt_grab_index = 9'h000;
    end else if (rd_grab && pixel_capture_ff[`OMR_GRAB_VALID_BIT]) begin
      nxt_grab = 8'h00;
      // Column-major order wraps after the last of 484 pixels
      nxt_grab_index = (grab_index_ff == `OMR_GRAB_LAST) ? 9'h000 :
                       grab_index_ff + 9'h001;
    end else if (pixel_valid && !pixel_capture_ff[`OMR_GRAB_VALID_BIT] &&
                 pixel.index == grab_index_ff) begin
      // The valid bit blocks further captures until this capture is read
      nxt_grab = {1'b1, pixel.value[7:1]};
    end
    // Frame results; the motion set wins over a same-cycle clear
    if (frame_valid) begin
      nxt_x = sat_add(nxt_x, frame.dx, wide);
      nxt_y = sat_add(nxt_y, frame.dy, wide);
      if (frame.dx != 12'h000 || frame.dy != 12'h000) begin
        nxt_flag = 1'b1;
      end
      nxt_quality = clamp8(frame.feature_cnt[8:1], `OMR_QUALITY_MAX);
      nxt_bright = clamp8(frame.pix_peak, `OMR_PIX_CEIL);
      nxt_dark = clamp8(frame.pix_low, `OMR_PIX_CEIL);
      nxt_sum = (frame.pix_sum > `OMR_SUM_MAX) ? 8'(`OMR_SUM_MAX >> 9) :
                frame.pix_sum[16:9];
      // Exposure loop: shorten on glare, lengthen on a dim frame
      if (frame.pix_peak > `OMR_EXP_PEAK_HI ||
          frame.pix_sum[16:9] > `OMR_EXP_AVG_HI) begin
        if (shutter_ff > `OMR_EXP_MIN + `OMR_EXP_STEP) begin
          nxt_shutter = shutter_ff - `OMR_EXP_STEP;
        end
      end else if (frame.pix_peak < `OMR_EXP_PEAK_LO &&
                   frame.pix_sum[16:9] < `OMR_EXP_AVG_LO) begin
        if (shutter_ff < 16'hffff - `OMR_EXP_STEP) begin
          nxt_shutter = shutter_ff + `OMR_EXP_STEP;
        end
      end
    end
  end

  // Register file
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      x_ff <= 12'h000;
      y_ff <= 12'h000;
      x_hi_ff <= 4'h0;
      y_hi_ff <= 4'h0;
      motion_seen_flag_ff <= 1'b0;
      surface_quality_ff <= 8'h00;
      shutter_ff <= `OMR_RST_SHUTTER;
      shut_low_shadow_ff <= 8'h00;
      shadow_armed_ff <= 1'b0;
      brightest_pixel_ff <= `OMR_RST_BRIGHT;
      pixel_sum_upper_ff <= `OMR_RST_SUM;
      darkest_pixel_ff <= 8'h00;
      pixel_capture_ff <= 8'h00;
      grab_index_ff <= 9'h000;
      ctrl_ff <= `OMR_RST_CTRL;
    end else begin
      x_ff <= nxt_x;
      y_ff <= nxt_y;
      x_hi_ff <= nxt_x_hi;
      y_hi_ff <= nxt_y_hi;
      motion_seen_flag_ff <= nxt_flag;
      surface_quality_ff <= nxt_quality;
      shutter_ff <= nxt_shutter;
      shut_low_shadow_ff <= nxt_shadow;
      shadow_armed_ff <= nxt_armed;
      brightest_pixel_ff <= nxt_bright;
      pixel_sum_upper_ff <= nxt_sum;
      darkest_pixel_ff <= nxt_dark;
      pixel_capture_ff <= nxt_grab;
      grab_index_ff <= nxt_grab_index;
      ctrl_ff <= nxt_ctrl;
    end
  end

endmodule

// ### omr_readout_props.sv
// Checker for the readout block's pins: select, data out and the shutter loop.
// Assumes it is bound onto omr_readout and sees only that module's ports.
`timescale 1ns/10ps
module omr_readout_chk
  import omr_pkg::*;
(
  input wire logic clock,
  input wire logic nrst,
  input wire logic ncs,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic miso_oe,
  input wire logic frame_valid,
  input wire omr_frame_t frame,
  input wire logic pixel_valid,
  input wire omr_pixel_t pixel,
  input wire logic [15:0] shutter_time
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);

  // Output enable follows select once the sync flops have settled
  a_oe_idle: assert property (ncs [*5] |-> !miso_oe)
    else $error("miso_oe high while deselected");
  a_oe_select: assert property ((!ncs) [*5] |-> miso_oe)
    else $error("miso_oe low while selected");
  // Data out only moves after a clock fall or a select change
  a_miso_hold: assert property ((sclk && $stable(ncs)) [*8] |-> $stable(miso))
    else $error("miso moved while sclk stayed high");
  a_shut_reset: assert property ($rose(nrst) |-> shutter_time == 16'h0064)
    else $error("shutter not at reset value");
  // The loop moves only in steps of four, and only after a frame
  a_shut_step: assert property ($changed(shutter_time) |->
    (shutter_time == $past(shutter_time) + 16'h0004) ||
    (shutter_time == $past(shutter_time) - 16'h0004))
    else $error("shutter step not four");
  a_shut_cause: assert property ($changed(shutter_time) |->
    $past(frame_valid) || $past(frame_valid, 2) || $past(frame_valid, 3))
    else $error("shutter moved without a frame");
  a_shut_down: assert property (frame_valid && frame.pix_peak > 8'hf0 &&
    shutter_time >= 16'h0010 |-> ##[1:3] shutter_time == $past(shutter_time) - 16'h0004)
    else $error("bright frame did not shorten shutter");
  a_shut_up: assert property (frame_valid && frame.pix_peak < 8'h80 &&
    frame.pix_sum[16:9] < 8'h40 && shutter_time < 16'hff00 |->
    ##[1:3] shutter_time == $past(shutter_time) + 16'h0004)
    else $error("dark frame did not lengthen shutter");

  c_select: cover property ($fell(ncs));
  c_bright: cover property (frame_valid && frame.pix_peak > 8'hf0);
  c_moved: cover property ($changed(shutter_time));
endmodule

bind omr_readout omr_readout_chk u_chk (.clock(clock), .nrst(nrst), .ncs(ncs), .sclk(sclk),
  .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .frame_valid(frame_valid), .frame(frame),
  .pixel_valid(pixel_valid), .pixel(pixel), .shutter_time(shutter_time));

// ### omr_readout_test.sv
// Self-checking bench: reset map, motion counts, statistics, shutter, grabber.
// Assumes the host model drives the serial pins; frames and pixels come from here.
`timescale 1ns/10ps
module omr_readout_test
  import omr_pkg::*;
;
  logic clock, nrst, frame_valid, pixel_valid, ncs, sclk, mosi, miso, miso_oe;
  omr_frame_t frame;
  omr_pixel_t pixel;
  logic [15:0] shutter_time;
  logic [7:0] rd;
  logic miso_line;
  int n_fail = 0;
  int total_checks = 0;
  int accx, accy, wide, moved, shut, esq, ebr, edk, esum, k;
  logic [7:0] rst_tab [2:14] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h64, 8'hd0, 8'h80,
    8'h00, 8'h00, 8'h00, 8'h01, 8'h00};

  omr_readout dut (.clock(clock), .nrst(nrst), .ncs(ncs), .sclk(sclk), .mosi(mosi),
    .miso(miso), .miso_oe(miso_oe), .frame_valid(frame_valid), .frame(frame),
    .pixel_valid(pixel_valid), .pixel(pixel), .shutter_time(shutter_time));
  // A released data line shows the inverse of its last level, so stale bits are caught
  assign miso_line = miso_oe ? miso : ~miso;
  omr_host_model host (.ncs(ncs), .sclk(sclk), .mosi(mosi), .miso(miso_line));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Register read with a random pause, slow or prompt, after the command; writes use no pause
  task automatic rchk(input logic [6:0] a, input logic [7:0] exp, input string what);
    host.xfer({1'b0, a}, 8'h00, $urandom_range(3, 0), rd);
    check8(what, exp, rd);
  endtask
  task automatic wreg(input logic [6:0] a, input logic [7:0] d);
    host.xfer({1'b1, a}, d, 0, rd);
  endtask

  function automatic int sat(input int v, input int lim);
    // Counts saturate at the two's complement ends: the low end is one below -lim
    return v > lim ? lim : (v < -lim - 1 ? -lim - 1 : v);
  endfunction
  // Fixed value per index: the sensor is held still during grabbing
  function automatic logic [7:0] pix_val(input int idx);
    return 8'(idx * 37 + 11);
  endfunction

  // One frame pulse; the reference model tracks counts, statistics and exposure
  task automatic send_frame(input int dx, input int dy, input int sum);
    int mx, mn, sq, lim;
    // Random fields span their full width so the register ceilings are exercised
    mx = $urandom_range(255, 0);
    mn = $urandom_range(mx, 0);
    sq = $urandom_range(511, 0);
    if (sum < 0) sum = $urandom_range(131071, 0);
    esq = (sq >> 1) > 180 ? 180 : (sq >> 1);
    ebr = mx > 254 ? 254 : mx;
    edk = mn > 254 ? 254 : mn;
    esum = (sum >> 9) > 240 ? 240 : (sum >> 9);
    lim = wide ? 2047 : 127;
    accx = sat(accx + dx, lim);
    accy = sat(accy + dy, lim);
    if (dx != 0 || dy != 0) moved = 1;
    if (mx > 240 || esum > 192) shut = shut - 4;
    else if (mx < 128 && esum < 64) shut = shut + 4;
    @(negedge clock);
    frame = '{dx: 12'(dx), dy: 12'(dy), feature_cnt: 9'(sq), pix_sum: 17'(sum),
      pix_peak: 8'(mx), pix_low: 8'(mn)};
    frame_valid = 1'b1;
    @(negedge clock);
    frame_valid = 1'b0;
    repeat (4) @(negedge clock);
  endtask

  // Streams indices 0..5 twice; the second pass must not overwrite a capture
  task automatic send_pixels();
    for (int p = 0; p < 12; p++) begin
      @(negedge clock);
      pixel = '{index: 9'(p % 6), value: p < 6 ? pix_val(p) : ~pix_val(p - 6)};
      pixel_valid = 1'b1;
    end
    @(negedge clock);
    pixel_valid = 1'b0;
  endtask

  initial begin
    repeat (100000) @(posedge clock);
    n_fail++;
    conclude();
  end

  initial begin
    nrst = 1'b0;
    frame_valid = 1'b0;
    pixel_valid = 1'b0;
    frame = '0;
    pixel = '0;
    accx = 0;
    accy = 0;
    wide = 0;
    moved = 0;
    shut = 100;
    void'($urandom(67));
    repeat (3) @(negedge clock);
    nrst = 1'b1;
    // Reset map, ending on an unmapped address
    for (k = 2; k <= 14; k++) rchk(7'(k), rst_tab[k], "reset value");
    for (k = 0; k < 4; k++) send_frame(int'($urandom_range(40, 0)) - 20,
      int'($urandom_range(40, 0)) - 20, -1);
    rchk(7'h02, moved ? 8'h80 : 8'h00, "status");
    rchk(7'h03, 8'(accx), "x count");
    rchk(7'h04, 8'(accy), "y count");
    accx = 0;
    accy = 0;
    rchk(7'h03, 8'h00, "x after read");
    // Largest pixel sum, then saturation of the 8-bit counts
    send_frame(100, -100, 122936);
    rchk(7'h09, 8'hf0, "sum at limit");
    send_frame(100, -100, -1);
    rchk(7'h03, 8'h7f, "x saturated");
    rchk(7'h04, 8'h80, "y saturated");
    send_frame(5, 6, -1);
    wreg(7'h02, 8'hff);
    accx = 0;
    accy = 0;
    rchk(7'h02, 8'h00, "status cleared");
    rchk(7'h04, 8'h00, "y cleared");
    // Wide reporting: low bytes then nibbles, read back to back
    wreg(7'h0d, 8'h80);
    wide = 1;
    rchk(7'h0d, 8'h80, "control");
    send_frame(1000, -300, -1);
    send_frame(1000, -300, -1);
    rchk(7'h03, 8'(accx), "x wide");
    rchk(7'h04, 8'(accy), "y wide");
    rchk(7'h0c, {4'(accx >> 8), 4'(accy >> 8)}, "nibbles");
    rchk(7'h05, 8'(esq), "quality");
    rchk(7'h08, 8'(ebr), "brightest");
    rchk(7'h09, 8'(esum), "sum");
    rchk(7'h0a, 8'(edk), "darkest");
    rchk(7'h06, 8'(shut >> 8), "shutter upper");
    rchk(7'h07, 8'(shut), "shutter lower");
    check8("shutter port", 8'(shut), shutter_time[7:0]);
    // Grabber walk down the first column, with a restart from the origin
    wreg(7'h0b, 8'h5a);
    for (k = 0; k < 4; k++) begin
      if (k == 3) wreg(7'h0b, 8'ha5);
      send_pixels();
      rchk(7'h0b, 8'h80 | (pix_val(k == 3 ? 0 : k) >> 1), "grab");
      host.xfer(8'h0b, 8'h00, 0, rd);
      check8("grab valid after read", 8'h00, rd & 8'h80);
    end
    conclude();
  end
endmodule
